/* verilog/fsps_pkg.sv */
// Purpose: constants for the flash self-programming sequencer
// Assumes: 100 MHz clock, 16-bit pointer, 32-word pages
// Notes:   programming count derives from a time in ns; window counts are given in cycles
package fsps_pkg;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          PROG_TIME_NS    = 4_000_000;
	localparam int          PROG_CYCLES     = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam logic [2:0]  STORE_WINDOW    = 3'h4;
	localparam logic [2:0]  LOAD_WINDOW     = 3'h3;
	localparam logic [4:0]  CMD_LOAD        = 5'h01;
	localparam logic [4:0]  CMD_ERASE       = 5'h03;
	localparam logic [4:0]  CMD_WRITE       = 5'h05;
	localparam logic [4:0]  CMD_LOCK        = 5'h09;
	localparam logic [4:0]  CMD_REENABLE    = 5'h11;
	localparam logic [15:0] PTR_LOCK        = 16'h0001;
	localparam logic [15:0] PTR_FUSE_LOW    = 16'h0000;
	localparam logic [15:0] PTR_FUSE_HIGH   = 16'h0003;
	localparam logic [15:0] PTR_FUSE_EXT    = 16'h0002;
	localparam logic [7:0]  LOCK_RESET      = 8'hFF;
	localparam int          WORD_LSB        = 1;
	localparam int          PAGE_LSB        = 6;
	typedef enum logic [3:0] {
		FSPS_IDLE  = 4'b0001,
		FSPS_ARMED = 4'b0010,
		FSPS_BUSY  = 4'b0100,
		FSPS_DONE  = 4'b1000
	} fsps_state_t;
endpackage

/* verilog/fsps_top.sv */
// Purpose: flash self-programming sequencer core logic
// Assumes: core presents one-cycle strobes for control write, store and load
// Notes:   flash array itself is outside; this block drives its controls
//          and serves it page words from the temporary buffer
`timescale 1ns/10ps
module fsps_top import fsps_pkg::*; #(
	parameter int PAGE_WORDS  = 32,
	parameter int PAGE_BITS   = 7,
	parameter int NO_READ_WHILE_WRITE_SECTION_PAGE   = 96,
	parameter int PROG_COUNT  = PROG_CYCLES
) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 ctrl_wr,
	input  wire logic [7:0]           ctrl_wdata,
	output logic      [7:0]           ctrl_rdata,
	input  wire logic                 store_strobe,
	input  wire logic                 load_strobe,
	input  wire logic [15:0]          pointer,
	input  wire logic [15:0]          data_pair,
	input  wire logic                 eeprom_write_busy,
	input  wire logic [7:0]           fuse_low_byte,
	input  wire logic [7:0]           fuse_high_byte,
	input  wire logic [3:0]           fuse_extended_byte,
	output logic      [7:0]           load_rdata,
	output logic                      load_rvalid,
	output logic                      ready_irq,
	output logic                      core_halt,
	output logic                      section_read_block,
	output logic                      flash_erase,
	output logic                      flash_write,
	output logic      [PAGE_BITS-1:0] flash_page,
	input  wire logic [$clog2(PAGE_WORDS)-1:0] flash_word,
	output logic      [15:0]          flash_wdata,
	output logic      [7:0]           lock_byte
);
	// ***************************************************************
	// reset release
	// ***************************************************************
	logic rst_meta_reg;
	logic rst_sync_b;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_sync_b   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_b   <= rst_meta_reg;
		end
	end

	// ***************************************************************
	// control register and arming window
	// ***************************************************************
	fsps_state_t          state_reg;
	logic [4:0]           cmd_reg;
	logic                 irq_en_reg;
	logic                 busy_flag_reg;
	logic [2:0]           win_reg;
	logic [31:0]          prog_cnt_reg;
	logic                 op_no_read_while_write_section_reg;
	logic                 op_is_lock_reg;
	logic [PAGE_BITS-1:0] page_reg;
	logic [7:0]           lock_reg;
	logic [15:0]          buf_mem [PAGE_WORDS];
	logic                 enable_bit;
	logic                 cmd_ok;
	logic                 store_go;
	logic                 lock_read;
	logic [PAGE_BITS-1:0] ptr_page;

	assign ptr_page   = pointer[PAGE_LSB +: PAGE_BITS];
	assign enable_bit = (state_reg == FSPS_ARMED) || (state_reg == FSPS_BUSY);
	assign cmd_ok     = (ctrl_wdata[4:0] == CMD_LOAD) || (ctrl_wdata[4:0] == CMD_ERASE)
		|| (ctrl_wdata[4:0] == CMD_WRITE) || (ctrl_wdata[4:0] == CMD_LOCK)
		|| (ctrl_wdata[4:0] == CMD_REENABLE);
	// late stores fall outside ARMED and are ignored
	assign store_go   = (state_reg == FSPS_ARMED) && store_strobe && !eeprom_write_busy;
	assign lock_read  = (state_reg == FSPS_ARMED) && (cmd_reg == CMD_LOCK) && load_strobe
		&& (win_reg < LOAD_WINDOW) && !eeprom_write_busy;

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq_en_reg <= 1'b0;
		end else if (ctrl_wr) begin
			irq_en_reg <= ctrl_wdata[7];
		end
	end

	// ***************************************************************
	// command decode
	// ***************************************************************
	logic arm_go;
	logic page_go;
	logic lock_go;
	logic prog_go;
	logic prog_end;
	// a second control write is refused while armed or busy
	assign arm_go   = (state_reg == FSPS_IDLE) && ctrl_wr && cmd_ok
		&& !eeprom_write_busy;
	assign page_go  = store_go
		&& ((cmd_reg == CMD_ERASE) || (cmd_reg == CMD_WRITE));
	assign lock_go  = store_go && (cmd_reg == CMD_LOCK);
	assign prog_go  = page_go || lock_go;
	// busy ignores new control writes until the count runs out
	assign prog_end = (state_reg == FSPS_BUSY) && (prog_cnt_reg == 32'h0);

	// ***************************************************************
	// sequencer state
	// ***************************************************************
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_reg <= FSPS_IDLE;
		end else begin
			case (state_reg)
				FSPS_IDLE: begin
					if (arm_go) begin
						state_reg <= FSPS_ARMED;
					end
				end
				FSPS_ARMED: begin
					if (lock_read) begin
						state_reg <= FSPS_IDLE;
					end else if (prog_go) begin
						state_reg <= FSPS_BUSY;
					// a store with load or re-enable armed ends the window without starting a timed operation
					end else if (store_go) begin
						state_reg <= FSPS_IDLE;
					end else if (win_reg == STORE_WINDOW - 3'h1) begin
						state_reg <= FSPS_IDLE;
					end
				end
				FSPS_BUSY: begin
					if (prog_end) begin
						state_reg <= FSPS_DONE;
					end
				end
				FSPS_DONE: begin
					state_reg <= FSPS_IDLE;
				end
				default: begin
					state_reg <= FSPS_IDLE;
				end
			endcase
		end
	end

	// the code stays for the decode of the whole operation
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cmd_reg <= 5'h00;
		end else if (arm_go) begin
			cmd_reg <= ctrl_wdata[4:0];
		end
	end

	// ***************************************************************
	// arming window
	// ***************************************************************
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			win_reg <= 3'h0;
		end else if (arm_go) begin
			win_reg <= 3'h0;
		end else if (state_reg == FSPS_ARMED) begin
			win_reg <= win_reg + 3'h1;
		end
	end

	// ***************************************************************
	// programming timer
	// ***************************************************************
	// lock writes take the same time as page operations
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			prog_cnt_reg <= 32'h0;
		end else if (prog_go) begin
			prog_cnt_reg <= 32'(PROG_COUNT - 1);
		end else if ((state_reg == FSPS_BUSY) && !prog_end) begin
			prog_cnt_reg <= prog_cnt_reg - 32'h1;
		end
	end

	// ***************************************************************
	// latched operation
	// ***************************************************************
	// page and section are held so the pointer is free during the operation
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			page_reg       <= '0;
			op_no_read_while_write_section_reg    <= 1'b0;
			op_is_lock_reg <= 1'b0;
		end else if (page_go) begin
			page_reg       <= ptr_page;
			op_no_read_while_write_section_reg    <= (32'(ptr_page) >= NO_READ_WHILE_WRITE_SECTION_PAGE);
			op_is_lock_reg <= 1'b0;
		end else if (lock_go) begin
			op_no_read_while_write_section_reg    <= 1'b0;
			op_is_lock_reg <= 1'b1;
		end
	end

	// ***************************************************************
	// section busy flag
	// ***************************************************************
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			busy_flag_reg <= 1'b0;
		end else if (store_go && ((cmd_reg == CMD_ERASE) || (cmd_reg == CMD_WRITE))) begin
			busy_flag_reg <= 1'b1;
		end else if (store_go && ((cmd_reg == CMD_LOAD) || (cmd_reg == CMD_REENABLE))) begin
			busy_flag_reg <= 1'b0;
		end
	end

	// ***************************************************************
	// temporary page buffer
	// ***************************************************************
	logic buf_clear;
	logic buf_load;
	logic write_done;
	assign write_done = (state_reg == FSPS_DONE) && (cmd_reg == CMD_WRITE);
	assign buf_clear  = write_done || (store_go && (cmd_reg == CMD_REENABLE))
		|| (eeprom_write_busy && (state_reg == FSPS_ARMED) && (cmd_reg == CMD_LOAD));
	assign buf_load   = store_go && (cmd_reg == CMD_LOAD);

	genvar gi;
	generate
		for (gi = 0; gi < PAGE_WORDS; gi++) begin : g_buf
			always_ff @(posedge clk or negedge rst_sync_b) begin
				if (!rst_sync_b) begin
					buf_mem[gi] <= 16'hFFFF;
				end else if (buf_clear) begin
					buf_mem[gi] <= 16'hFFFF;
				end else if (buf_load && (32'(pointer[WORD_LSB +: $clog2(PAGE_WORDS)]) == gi)) begin
					buf_mem[gi] <= data_pair;
				end
			end
		end
	endgenerate

	// ***************************************************************
	// buffer readout for the flash array
	// ***************************************************************
	// the flash array steps flash_word to fetch each word it programs
	// registered so the array sees a settled word one cycle after it asks
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			flash_wdata <= 16'hFFFF;
		end else begin
			flash_wdata <= buf_mem[flash_word];
		end
	end

	// ***************************************************************
	// lock bits
	// ***************************************************************
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			lock_reg <= LOCK_RESET;
		end else if (store_go && (cmd_reg == CMD_LOCK)) begin
			lock_reg[5:2] <= lock_reg[5:2] & data_pair[5:2];
		end
	end

	// ***************************************************************
	// fuse and lock readback
	// ***************************************************************
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			load_rdata  <= 8'h00;
			load_rvalid <= 1'b0;
		end else begin
			load_rvalid <= lock_read;
			if (lock_read) begin
				case (pointer)
					PTR_LOCK:      load_rdata <= {2'h3, lock_reg[5:0]};
					PTR_FUSE_LOW:  load_rdata <= fuse_low_byte;
					PTR_FUSE_HIGH: load_rdata <= fuse_high_byte;
					PTR_FUSE_EXT:  load_rdata <= {4'hF, fuse_extended_byte};
					default:       load_rdata <= 8'hFF;
				endcase
			end
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	logic busy_prog;
	assign busy_prog = (state_reg == FSPS_BUSY) && !op_is_lock_reg;
	// lock programming never halts or blocks
	assign core_halt          = busy_prog && op_no_read_while_write_section_reg;
	assign section_read_block = busy_flag_reg;
	assign flash_erase        = busy_prog && (cmd_reg == CMD_ERASE);
	assign flash_write        = busy_prog && (cmd_reg == CMD_WRITE);
	assign flash_page         = page_reg;
	assign lock_byte          = lock_reg;
	assign ready_irq          = irq_en_reg && !enable_bit;
	assign ctrl_rdata = {irq_en_reg, busy_flag_reg, 1'b0,
		enable_bit ? cmd_reg[4:1] : 4'h0, enable_bit};
endmodule // fsps_top

/* verification/fsps_chk.sv */
// Purpose: port assertions for the sequencer
// Assumes: PROG_COUNT shortened in simulation
// Notes:   bound into fsps_top
`timescale 1ns/10ps
module fsps_chk import fsps_pkg::*; #(
	parameter int PAGE_BITS = 7,
	parameter int NO_READ_WHILE_WRITE_SECTION_PAGE = 96
) (
	input wire logic                 clk,
	input wire logic                 rst_b,
	input wire logic                 store_strobe,
	input wire logic                 load_strobe,
	input wire logic                 eeprom_write_busy,
	input wire logic                 load_rvalid,
	input wire logic                 ready_irq,
	input wire logic                 core_halt,
	input wire logic                 section_read_block,
	input wire logic                 flash_erase,
	input wire logic                 flash_write,
	input wire logic [PAGE_BITS-1:0] flash_page
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic busy;
	assign busy = flash_erase | flash_write;
	a_erase_cause: assert property ($rose(flash_erase) |-> $past(store_strobe))
		else $error("erase began without a store");
	a_write_cause: assert property ($rose(flash_write) |-> $past(store_strobe))
		else $error("write began without a store");
	a_busy_flag: assert property ($rose(busy) |-> section_read_block)
		else $error("section busy flag not set");
	a_halt_upper: assert property (busy && flash_page >= NO_READ_WHILE_WRITE_SECTION_PAGE |-> core_halt)
		else $error("core not halted for upper page");
	a_halt_cause: assert property (core_halt |-> busy && flash_page >= NO_READ_WHILE_WRITE_SECTION_PAGE)
		else $error("core halted without cause");
	a_read_cause: assert property (load_rvalid |-> $past(load_strobe) || $past(load_strobe, 2))
		else $error("readback without a load");
	a_read_pulse: assert property (load_rvalid |=> !load_rvalid)
		else $error("readback valid too long");
	a_op_bound: assert property ($rose(busy) |-> busy[*8] ##[1:30] !busy)
		else $error("operation length out of range");
	a_eeprom_block: assert property ($rose(busy) |-> !$past(eeprom_write_busy))
		else $error("operation began during eeprom write");
	a_irq_idle: assert property (ready_irq |-> !busy)
		else $error("ready request during operation");
endmodule // fsps_chk

bind fsps_top fsps_chk #(.PAGE_BITS(PAGE_BITS), .NO_READ_WHILE_WRITE_SECTION_PAGE(NO_READ_WHILE_WRITE_SECTION_PAGE)) u_chk (.*);

/* verification/fsps_core_model.sv */
// Purpose: core model issuing control writes, stores and loads
// Assumes: one-cycle strobes
// Notes:   released pointer and data show inverted values
`timescale 1ns/10ps
module fsps_core_model (
	input  wire logic        clk,
	output logic             ctrl_wr,
	output logic [7:0]       ctrl_wdata,
	output logic             store_strobe,
	output logic             load_strobe,
	output logic [15:0]      pointer,
	output logic [15:0]      data_pair
);
	initial begin
		ctrl_wr = 1'b0;
		ctrl_wdata = 8'h00;
		store_strobe = 1'b0;
		load_strobe = 1'b0;
		pointer = 16'h0000;
		data_pair = 16'h0000;
	end
	// gap: edges from control write to the strobe
	task automatic spm(input logic [7:0] cw, input logic [15:0] p, input logic [15:0] d,
		input int gap, input logic lpm);
		@(posedge clk);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= cw;
		pointer <= p;
		data_pair <= d;
		@(posedge clk);
		ctrl_wr <= 1'b0;
		repeat (gap - 1) @(posedge clk);
		if (lpm)
			load_strobe <= 1'b1;
		else
			store_strobe <= 1'b1;
		@(posedge clk);
		load_strobe <= 1'b0;
		store_strobe <= 1'b0;
		pointer <= ~p;
		data_pair <= ~d;
	endtask
endmodule // fsps_core_model

/* verification/flash_self_programming_sequencer_tb.sv */
// Purpose: self-checking bench for the sequencer
// Assumes: PROG_COUNT shortened to 10 cycles
// Notes:   core model makes the control writes and strobes
`timescale 1ns/10ps
module flash_self_programming_sequencer_tb import fsps_pkg::*;;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        eeprom_write_busy = 1'b0;
	logic [7:0]  fuse_low_byte = 8'h00;
	logic [7:0]  fuse_high_byte = 8'h00;
	logic [3:0]  fuse_extended_byte = 4'h0;
	logic        ctrl_wr, store_strobe, load_strobe, load_rvalid, ready_irq, core_halt;
	logic        section_read_block, flash_erase, flash_write;
	logic [7:0]  ctrl_wdata, ctrl_rdata, load_rdata, lock_byte;
	logic [15:0] pointer, data_pair;
	logic [6:0]  flash_page;
	logic [4:0]  flash_word = 5'h00;
	logic [15:0] flash_wdata;
	int          errors = 0;
	int          checks = 0;
	always #5 clk = ~clk;
	fsps_top #(.PROG_COUNT(10)) u_dut (.*);
	fsps_core_model u_core (.*);
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wait_idle;
		for (int n = 0; n < 60; n++) begin
			@(posedge clk);
			#1;
			if ({flash_erase, flash_write, ctrl_rdata[0]} === 3'h0)
				return;
		end
		errors++;
		complete_run;
	endtask
	// mask in the upper byte, expected readback in the lower
	function automatic logic [15:0] read_exp(input logic [1:0] p, input logic [7:0] lkv);
		case (p)
			2'h0: return {8'hFF, fuse_low_byte};
			2'h1: return {8'h3F, 2'b00, lkv[5:0]};
			2'h2: return {8'h0F, 4'h0, fuse_extended_byte};
			default: return {8'hFF, fuse_high_byte};
		endcase
	endfunction
	initial begin
		logic [6:0]  pg;
		logic [7:0]  d;
		logic [7:0]  lk;
		logic [15:0] e;
		logic [4:0]  wd;
		logic [15:0] dv;
		void'($urandom(32'h4EA6));
		lk = LOCK_RESET;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		fuse_low_byte <= 8'($urandom);
		fuse_high_byte <= 8'($urandom);
		fuse_extended_byte <= 4'($urandom);
		repeat (4) @(posedge clk);
		#1;
		chk("lock_byte", 16'(LOCK_RESET), 16'(lock_byte));
		for (int i = 0; i < 2; i++) begin
			pg = i ? 7'(96 + $urandom_range(31)) : 7'($urandom_range(95));
			u_core.spm({3'h4, CMD_ERASE}, {3'h0, pg, 6'($urandom)}, 16'($urandom), 1, 1'b0);
			#1;
			chk("flash_erase", 16'h1, 16'(flash_erase));
			chk("flash_page", 16'(pg), 16'(flash_page));
			chk("core_halt", 16'(i), 16'(core_halt));
			chk("busy_flag", 16'h1, 16'(section_read_block));
			chk("ready_irq", 16'h0, 16'(ready_irq));
			u_core.spm({3'h4, CMD_WRITE}, 16'h0, 16'h0, 1, 1'b0);
			#1;
			chk("flash_write", 16'h0, 16'(flash_write));
			wait_idle;
			chk("ready_irq", 16'h1, 16'(ready_irq));
			wd = 5'($urandom);
			dv = 16'($urandom);
			u_core.spm({3'h0, CMD_LOAD}, {10'($urandom), wd, 1'($urandom)}, dv, 1, 1'b0);
			#1;
			chk("busy_flag", 16'h0, 16'(section_read_block));
			@(posedge clk);
			flash_word <= wd;
			@(posedge clk);
			#1;
			chk("flash_wdata", dv, flash_wdata);
			u_core.spm({3'h0, CMD_WRITE}, {3'h0, pg, 6'h00}, 16'hFFFF, 4, 1'b0);
			#1;
			chk("flash_write", 16'h1, 16'(flash_write));
			chk("flash_page", 16'(pg), 16'(flash_page));
			chk("core_halt", 16'(i), 16'(core_halt));
			wait_idle;
			repeat (2) @(posedge clk);
			#1;
			chk("flash_wdata", 16'hFFFF, flash_wdata);
			u_core.spm({3'h0, CMD_REENABLE}, 16'h0, 16'h0, 1, 1'b0);
			#1;
			chk("busy_flag", 16'h0, 16'(section_read_block));
		end
		for (int g = 0; g < 2; g++) begin
			@(posedge clk);
			eeprom_write_busy <= (g == 1);
			u_core.spm({3'h0, CMD_ERASE}, 16'h0, 16'h0, g ? 1 : 5, 1'b0);
			#1;
			chk("flash_erase", 16'h0, 16'(flash_erase));
			chk("enable", 16'h0, 16'(ctrl_rdata[0]));
		end
		@(posedge clk);
		eeprom_write_busy <= 1'b0;
		wd = 5'($urandom);
		dv = 16'($urandom);
		u_core.spm({3'h0, CMD_LOAD}, {10'h000, wd, 1'b0}, dv, 1, 1'b0);
		@(posedge clk);
		flash_word <= wd;
		@(posedge clk);
		#1;
		chk("flash_wdata", dv, flash_wdata);
		fork
			u_core.spm({3'h0, CMD_LOAD}, {10'h000, wd, 1'b0}, ~dv, 3, 1'b0);
			begin
				repeat (2) @(posedge clk);
				eeprom_write_busy <= 1'b1;
			end
		join
		@(posedge clk);
		eeprom_write_busy <= 1'b0;
		@(posedge clk);
		#1;
		chk("flash_wdata", 16'hFFFF, flash_wdata);
		repeat (2) begin
			d = 8'($urandom) | 8'hC3;
			lk = {lk[7:6], lk[5:2] & d[5:2], lk[1:0]};
			u_core.spm({3'h0, CMD_LOCK}, PTR_LOCK, {8'($urandom), d}, 1, 1'b0);
			#1;
			chk("open", 16'h0, 16'(core_halt | section_read_block));
			repeat (12) @(posedge clk);
			#1;
			chk("lock_byte", 16'(lk), 16'(lock_byte));
		end
		for (int k = 0; k < 4; k++) begin
			e = read_exp(2'(k), lk);
			u_core.spm({3'h0, CMD_LOCK}, 16'(k), 16'h0, 3, 1'b1);
			#1;
			if (load_rvalid !== 1'b1) begin
				@(posedge clk);
				#1;
			end
			chk("load_rvalid", 16'h1, 16'(load_rvalid));
			chk("load_rdata", 16'(e[7:0]), 16'(load_rdata & e[15:8]));
			chk("enable", 16'h0, 16'(ctrl_rdata[0]));
		end
		complete_run;
	end
endmodule // flash_self_programming_sequencer_tb
